// File: core/accel_msg_framer.sv
// Purpose: Serial slave framer for the dual-axis acceleration sensor
// Assumes: SPI pins asynchronous to REF_CLK, sensor inputs on REF_CLK
// Notes:   Response bytes are staged in a FIFO ahead of the shifter
//
// What this block does
// RULE_01: Status bits 2:0 give payload type
// RULE_02: Acceleration payload: Y high, Y low, X high, X low
// RULE_03: Status payload: detail, zero, temperature high, low
// RULE_04: Detail bits 7:3 carry self-test checks
// RULE_05: Detail bit 2 flags memory parity failure
// RULE_06: Detail bit 1 flags previous checksum failure
// RULE_07: Checksum is inverted low byte of sum
// RULE_08: Bad-checksum commands are discarded entirely
// RULE_09: Bad checksum flagged in next sent status
// RULE_10: After rejection keep last good payload type
// RULE_11: Payload type resets to acceleration
// RULE_12: Output checksum computed before loading shifter
// RULE_13: Data bytes frozen from checksum until loaded
// RULE_14: Status byte may change after checksum
// RULE_15: Host still reads status on checksum error
// RULE_16: Self-test adds offset to both axes
// RULE_17: Offset magnitude chosen by range variant
// RULE_18: Offset applied within 35 ms
// RULE_19: Host waits 35 ms after self-test off
// RULE_20: Command bits 3:0 select type, bit 6 self-test
// RULE_21: Input is command, four data, checksum
// RULE_22: Slave in clock mode 0
// RULE_23: Two's complement data, high byte first
// RULE_24: One select assertion frames six bytes
`timescale 1ns/1ps
`default_nettype none
module accel_msg_framer #(
    parameter int unsigned            SETTLE_CYCLES = accel_framer_pkg::CBIT_SETTLE_CYC,
    parameter int unsigned            REFRESH       = accel_framer_pkg::REFRESH_CYC,
    parameter logic [4:0][15:0]       CBIT_OFFSET   = {16'h00E6, 16'h0398, 16'h0EA6, 16'h2710, 16'h8E94}
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic        SPI_SCLK,
    input  wire logic        SPI_CS_N,
    input  wire logic        SPI_MOSI,
    output logic             SPI_MISO,
    output logic             SPI_MISO_OE,
    input  wire logic [15:0] ACC_Y,
    input  wire logic [15:0] ACC_X,
    input  wire logic [15:0] TEMP,
    input  wire logic [2:0]  RANGE_SEL,
    input  wire logic        SENSOR_FAIL,
    input  wire logic        ACC_Y_FAIL,
    input  wire logic        ACC_X_FAIL,
    input  wire logic        VREF_CAP_FAIL,
    input  wire logic        ACC_CAP_FAIL,
    input  wire logic        OTP_PARITY_FAIL,
    output logic [2:0]       MSG_TYPE,
    output logic             CBIT_EN,
    output logic             CSUM_ERR,
    output logic             CBIT_SETTLING
);
    localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);
    localparam int unsigned RW = $clog2(REFRESH + 1);

    // ****************************************************************
    // Pin synchronisers with agreement filter
    // ****************************************************************
    logic [2:0] pin_raw;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;

    assign pin_raw = {SPI_SCLK, SPI_CS_N, SPI_MOSI};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge REF_CLK) begin
                if (!RST_N) begin
                    s1[i]   <= (i == 1) ? 1'b1 : 1'b0;
                    s2[i]   <= (i == 1) ? 1'b1 : 1'b0;
                    s3[i]   <= (i == 1) ? 1'b1 : 1'b0;
                    filt[i] <= (i == 1) ? 1'b1 : 1'b0;
                end else if (CE) begin
                    s1[i] <= pin_raw[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        filt[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    logic sclk_q;
    logic cs_n_q;
    logic in_frame;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else if (CE) begin
            sclk_q <= filt[2];
            cs_n_q <= filt[1];
        end
    end

    assign in_frame  = ~filt[1];
    assign sclk_rise = in_frame & filt[2] & ~sclk_q;   // [RULE_22]
    assign cs_fall   = ~filt[1] & cs_n_q;               // [RULE_24]
    assign cs_rise   = filt[1] & ~cs_n_q;               // [RULE_24]

    // ****************************************************************
    // Receive shifter and message store
    // ****************************************************************
    logic [5:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_msg [accel_framer_pkg::MSG_BYTES];
    logic [7:0] next_rx_byte;

    assign next_rx_byte = {rx_sh[6:0], filt[0]};

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            bit_cnt <= '0;
            rx_sh   <= '0;
        end else if (CE) begin
            if (cs_fall) begin
                bit_cnt <= '0;
            end else if (sclk_rise) begin
                rx_sh <= next_rx_byte;                  // [RULE_21]
                if (bit_cnt != 6'h3F) begin
                    bit_cnt <= bit_cnt + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            for (int k = 0; k < accel_framer_pkg::MSG_BYTES; k++) begin
                rx_msg[k] <= '0;
            end
        end else if (CE && sclk_rise && bit_cnt[2:0] == 3'h7 && bit_cnt < 6'(accel_framer_pkg::MSG_BITS)) begin
            rx_msg[bit_cnt[5:3]] <= next_rx_byte;       // [RULE_21]
        end
    end

    // ****************************************************************
    // Input checksum check and command decode
    // ****************************************************************
    function automatic logic [7:0] csum5(input logic [7:0] b0, input logic [7:0] b1,
                                         input logic [7:0] b2, input logic [7:0] b3,
                                         input logic [7:0] b4);
        logic [10:0] s;
        s = 11'(b0) + 11'(b1) + 11'(b2) + 11'(b3) + 11'(b4);
        return ~s[7:0];
    endfunction

    logic       full_frame;
    logic       rx_ok;
    logic       rx_good;
    logic       rx_bad;
    logic [3:0] cmd_type;

    assign full_frame = cs_rise && bit_cnt == 6'(accel_framer_pkg::MSG_BITS);
    assign rx_ok      = csum5(rx_msg[0], rx_msg[1], rx_msg[2], rx_msg[3], rx_msg[4]) == rx_msg[5]; // [RULE_07]
    assign rx_good    = full_frame & rx_ok;
    assign rx_bad     = full_frame & ~rx_ok;
    assign cmd_type   = rx_msg[0][3:0];

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            MSG_TYPE <= accel_framer_pkg::MSG_TYPE_RST;        // [RULE_11]
            CBIT_EN  <= accel_framer_pkg::CBIT_RST;
        end else if (CE && rx_good) begin                      // [RULE_08] [RULE_10]
            CBIT_EN <= rx_msg[0][accel_framer_pkg::CMD_CBIT_POS];
            if (cmd_type == accel_framer_pkg::CMD_ACC) begin
                MSG_TYPE <= accel_framer_pkg::MSG_ACC;         // [RULE_01]
            end else if (cmd_type == accel_framer_pkg::CMD_STAT) begin
                MSG_TYPE <= accel_framer_pkg::MSG_STAT;        // [RULE_01]
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            CSUM_ERR <= accel_framer_pkg::CSUM_ERR_RST;
        end else if (CE && full_frame) begin
            CSUM_ERR <= rx_bad;                                // [RULE_09] [RULE_06]
        end
    end

    // ****************************************************************
    // Self-test settle timer
    // ****************************************************************
    logic [SW-1:0] settle_cnt;
    logic          cbit_q;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            settle_cnt <= '0;
            cbit_q     <= accel_framer_pkg::CBIT_RST;
        end else if (CE) begin
            cbit_q <= CBIT_EN;
            if (cbit_q != CBIT_EN) begin
                settle_cnt <= SW'(SETTLE_CYCLES);              // [RULE_18] [RULE_19]
            end else if (settle_cnt != '0) begin
                settle_cnt <= settle_cnt - SW'(1);
            end
        end
    end

    assign CBIT_SETTLING = (settle_cnt != '0);

    // ****************************************************************
    // Payload assembly
    // ****************************************************************
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic signed [17:0] s;
        s = 18'(signed'(a)) + signed'({2'b00, b});
        if (s > 18'sh07FFF) begin
            return 16'h7FFF;
        end else if (s < -18'sh08000) begin
            return 16'h8000;
        end
        return s[15:0];
    endfunction

    logic [15:0] cbit_ofs;
    logic [15:0] acc_y_out;
    logic [15:0] acc_x_out;
    logic [7:0]  status_now;
    logic [7:0]  detail_now;
    logic [31:0] data_now;

    assign cbit_ofs   = (RANGE_SEL < 3'(accel_framer_pkg::RANGE_COUNT)) ? CBIT_OFFSET[RANGE_SEL] : 16'h0000; // [RULE_17]
    assign acc_y_out  = CBIT_EN ? sat_add(ACC_Y, cbit_ofs) : ACC_Y;  // [RULE_16] [RULE_18]
    assign acc_x_out  = CBIT_EN ? sat_add(ACC_X, cbit_ofs) : ACC_X;  // [RULE_16]
    assign status_now = {SENSOR_FAIL, ACC_Y_FAIL, ACC_X_FAIL, CSUM_ERR, CBIT_EN, MSG_TYPE}; // [RULE_01] [RULE_09]
    assign detail_now = {ACC_X_FAIL, ACC_Y_FAIL, VREF_CAP_FAIL, ACC_CAP_FAIL,          // [RULE_04]
                         CBIT_EN, OTP_PARITY_FAIL, CSUM_ERR, accel_framer_pkg::DETAIL_BIT0}; // [RULE_05] [RULE_06]
    assign data_now   = (MSG_TYPE == accel_framer_pkg::MSG_STAT) ?
                        {detail_now, accel_framer_pkg::PAD_BYTE, TEMP} :                // [RULE_03]
                        {acc_y_out, acc_x_out};                                         // [RULE_02] [RULE_23]

    // ****************************************************************
    // Message builder
    // ****************************************************************
    typedef enum logic [2:0] {
        B_IDLE = 3'b001,
        B_CAPT = 3'b010,
        B_PUSH = 3'b100
    } build_state_t;

    build_state_t  state;
    logic [31:0]   data_cap;
    logic [7:0]    csum_cap;
    logic [2:0]    push_idx;
    logic [7:0]    push_byte;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic [7:0]    fifo_out_data;
    logic          flushing;
    logic          built;
    logic [RW-1:0] refresh_cnt;

    always_comb begin
        unique case (push_idx)
            3'h0:    push_byte = status_now;            // [RULE_14]
            3'h1:    push_byte = data_cap[31:24];       // [RULE_23]
            3'h2:    push_byte = data_cap[23:16];
            3'h3:    push_byte = data_cap[15:8];
            3'h4:    push_byte = data_cap[7:0];
            default: push_byte = csum_cap;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state    <= B_IDLE;
            data_cap <= '0;
            csum_cap <= '0;
            push_idx <= '0;
        end else if (CE) begin
            unique case (state)
                B_IDLE: begin
                    if (!built && !flushing && !in_frame && !fifo_out_valid) begin
                        state <= B_CAPT;
                    end
                end
                B_CAPT: begin
                    data_cap <= data_now;               // [RULE_13]
                    csum_cap <= csum5(status_now, data_now[31:24], data_now[23:16],
                                      data_now[15:8], data_now[7:0]); // [RULE_12] [RULE_07]
                    push_idx <= '0;
                    state    <= B_PUSH;
                end
                B_PUSH: begin
                    if (fifo_in_ready) begin
                        push_idx <= push_idx + 3'h1;
                        if (push_idx == 3'(accel_framer_pkg::MSG_BYTES - 1)) begin
                            state <= B_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            built       <= 1'b0;
            flushing    <= 1'b0;
            refresh_cnt <= '0;
        end else if (CE) begin
            if (state == B_PUSH && fifo_in_ready && push_idx == 3'(accel_framer_pkg::MSG_BYTES - 1)) begin
                built       <= 1'b1;
                refresh_cnt <= RW'(REFRESH);
            end else if (cs_rise || (built && !in_frame && refresh_cnt == '0)) begin
                built    <= 1'b0;
                flushing <= 1'b1;
            end else if (flushing && !fifo_out_valid) begin
                flushing <= 1'b0;
            end
            if (built && !in_frame && refresh_cnt != '0) begin
                refresh_cnt <= refresh_cnt - RW'(1);
            end
        end
    end

    // ****************************************************************
    // Outgoing byte FIFO
    // ****************************************************************
    logic tx_load;

    msg_fifo #(
        .WIDTH (accel_framer_pkg::BYTE_W),
        .DEPTH (accel_framer_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (state == B_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (push_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign tx_load        = cs_fall | (sclk_rise & bit_cnt[2:0] == 3'h7
                                       & bit_cnt < 6'(accel_framer_pkg::MSG_BITS - 1)); // [RULE_24]
    assign fifo_out_ready = tx_load | flushing;

    // ****************************************************************
    // Transmit shifter
    // ****************************************************************
    logic [7:0] tx_sh;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tx_sh <= '0;
        end else if (CE) begin
            if (tx_load) begin
                tx_sh <= fifo_out_valid ? fifo_out_data : 8'h00; // [RULE_12]
            end else if (sclk_rise) begin
                tx_sh <= {tx_sh[6:0], 1'b0};            // [RULE_22] [RULE_23]
            end
        end
    end

    assign SPI_MISO    = tx_sh[7];
    assign SPI_MISO_OE = in_frame;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N || !CE);

    type_acc_a: assert property (rx_good && cmd_type == accel_framer_pkg::CMD_ACC |=> MSG_TYPE == accel_framer_pkg::MSG_ACC) // [RULE_01]
        else $error("payload type not acceleration after command");
    type_stat_a: assert property (rx_good && cmd_type == accel_framer_pkg::CMD_STAT |=> MSG_TYPE == accel_framer_pkg::MSG_STAT) // [RULE_20]
        else $error("payload type not status after command");
    bad_discard_a: assert property (rx_bad |=> $stable(MSG_TYPE) && $stable(CBIT_EN) && CSUM_ERR) // [RULE_08]
        else $error("bad checksum message had an effect");
    good_clear_a: assert property (rx_good |=> !CSUM_ERR) // [RULE_06]
        else $error("checksum error kept after good message");
    reset_type_a: assert property (disable iff (1'b0) !RST_N |=> MSG_TYPE == accel_framer_pkg::MSG_ACC) // [RULE_11]
        else $error("payload type not acceleration after reset");
    csum_out_a: assert property (state == B_CAPT |=> csum_cap == csum5($past(status_now), data_cap[31:24],
                                 data_cap[23:16], data_cap[15:8], data_cap[7:0])) // [RULE_12]
        else $error("output checksum wrong");
    data_hold_a: assert property (state == B_PUSH && $past(state) == B_PUSH |-> $stable(data_cap)) // [RULE_13]
        else $error("data bytes changed before load");
    acc_order_a: assert property (state == B_CAPT && MSG_TYPE == accel_framer_pkg::MSG_ACC && !CBIT_EN
                                  |=> data_cap == {$past(ACC_Y), $past(ACC_X)}) // [RULE_02]
        else $error("acceleration byte order wrong");
    stat_pad_a: assert property (state == B_CAPT && MSG_TYPE == accel_framer_pkg::MSG_STAT
                                 |=> data_cap[23:16] == 8'h00 && data_cap[15:0] == $past(TEMP)) // [RULE_03]
        else $error("status payload layout wrong");
    settle_a: assert property ($changed(CBIT_EN) |=> CBIT_SETTLING [*2]) // [RULE_18]
        else $error("settle timer not started");
    frame_load_a: assert property (cs_fall && fifo_out_valid |=> SPI_MISO == $past(fifo_out_data[7]) && SPI_MISO_OE) // [RULE_24]
        else $error("first response bit not presented");

    good_frame_c: cover property (rx_good);
    bad_frame_c:  cover property (rx_bad ##1 CSUM_ERR);
    cbit_on_c:    cover property ($rose(CBIT_EN));
    stat_msg_c:   cover property (MSG_TYPE == accel_framer_pkg::MSG_STAT && cs_fall);

endmodule
`default_nettype wire

// File: core/accel_framer_pkg.sv
// Purpose: Shared constants of the accelerometer message framer
// Assumes: 10 MHz reference clock
// Notes:   Range count, field positions, reset values and cycle counts
package accel_framer_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned REF_CLK_HZ       = 10000000;
    localparam int unsigned CBIT_SETTLE_MS   = 35;
    localparam int unsigned CBIT_SETTLE_CYC  = CBIT_SETTLE_MS * (REF_CLK_HZ / 1000);
    localparam int unsigned REFRESH_CYC      = 64;

    // ****************************************************************
    // Message layout
    // ****************************************************************
    localparam int unsigned MSG_BYTES        = 6;
    localparam int unsigned MSG_BITS         = MSG_BYTES * 8;
    localparam int unsigned FIFO_DEPTH       = 8;
    localparam int unsigned BYTE_W           = 8;

    // ****************************************************************
    // Command byte fields
    // ****************************************************************
    localparam int unsigned CMD_CBIT_POS     = 6;
    localparam logic [3:0]  CMD_ACC          = 4'h1;
    localparam logic [3:0]  CMD_STAT         = 4'h2;

    // ****************************************************************
    // Status byte fields and payload type codes
    // ****************************************************************
    localparam logic [2:0]  MSG_ACC          = 3'h1;
    localparam logic [2:0]  MSG_STAT         = 3'h2;
    localparam logic [2:0]  MSG_TYPE_RST     = MSG_ACC;
    localparam logic        CBIT_RST         = 1'b0;
    localparam logic        CSUM_ERR_RST     = 1'b0;
    localparam logic [7:0]  PAD_BYTE         = 8'h00;
    localparam logic        DETAIL_BIT0      = 1'b1;

    // ****************************************************************
    // Range variants for the self-test offset
    // ****************************************************************
    localparam int unsigned RANGE_COUNT      = 5;

endpackage

// File: core/msg_fifo.sv
// Purpose: Small synchronous FIFO holding outgoing message bytes
// Assumes: Single clock, synchronous active-low reset
// Notes:   Read data come from the registered storage array
`timescale 1ns/1ps
`default_nettype none
module msg_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule
`default_nettype wire

// File: tb/spi_host.sv
// Purpose: Serial master model polling the framer
// Assumes: Mode 0, link clock period 800 ns
// Notes:   Clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    output logic        sclk,
    output logic        cs_n,
    output logic        mosi,
    input  wire logic   miso,
    output logic [47:0] rx,
    output logic        done
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        done = 1'b0;
    end
    // One select, six bytes, sample on rise
    task automatic xfer(input logic [47:0] tx, input logic tell);
        #37 cs_n = 1'b0;
        #800;
        for (int i = 47; i >= 0; i--) begin
            mosi = tx[i];
            #400 sclk = 1'b1;
            rx[i] = miso;
            #400 sclk = 1'b0;
        end
        #800 cs_n = 1'b1;
        mosi = ~mosi;
        done = tell;
        #4000 done = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb/accel_msg_framer_tb.sv
// Purpose: Self-checking bench for the message framer
// Assumes: Host model drives the serial pins
// Notes:   Expected responses queued, monitor compares
`timescale 1ns/1ps
`default_nettype none
module accel_msg_framer_tb;
    localparam logic [4:0][15:0] OFF = {16'h00E6, 16'h0398, 16'h0EA6, 16'h2710, 16'h8E94};
    localparam int               SETTLE = 20;
    localparam logic [7:0] CMDS [8] = '{8'h41, 8'h42, 8'h42, 8'h02, 8'h43, 8'h01, 8'h41, 8'h01};
    localparam logic       GOOD [8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic        clk = 1'b0, rst_n = 1'b0, sclk, cs_n, mosi, miso, oe, cb_en, c_err, settling, done, cb, err;
    logic [15:0] ay = 16'h1234, ax = 16'hF00D, tp = 16'h0A5C;
    logic [2:0]  rs = 3'h4, typ, mtype;
    logic [5:0]  fl = 6'h15;
    logic [47:0] rx;
    logic [47:0] expq[$];
    int          failures = 0, checks_done = 0, busy = 0;
    always #50 clk = ~clk;
    always @(posedge clk)
        if (settling) busy <= busy + 1;
    spi_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(oe ? miso : ~miso), .rx(rx), .done(done));
    accel_msg_framer #(.SETTLE_CYCLES(SETTLE), .REFRESH(60000), .CBIT_OFFSET(OFF)) uut (
        .REF_CLK(clk), .RST_N(rst_n), .CE(1'b1), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
        .SPI_MISO(miso), .SPI_MISO_OE(oe), .ACC_Y(ay), .ACC_X(ax), .TEMP(tp), .RANGE_SEL(rs),
        .SENSOR_FAIL(fl[5]), .ACC_Y_FAIL(fl[4]), .ACC_X_FAIL(fl[3]), .VREF_CAP_FAIL(fl[2]),
        .ACC_CAP_FAIL(fl[1]), .OTP_PARITY_FAIL(fl[0]), .MSG_TYPE(mtype), .CBIT_EN(cb_en),
        .CSUM_ERR(c_err), .CBIT_SETTLING(settling));
    // ****************************************************************
    // Model and checks
    // ****************************************************************
    function automatic logic [15:0] clip_add(input logic [15:0] a, input logic [15:0] o);
        int s;
        s = int'($signed(a)) + int'(o);
        return (s > 32767) ? 16'h7FFF : 16'(s);
    endfunction
    function automatic logic [47:0] msg();
        logic [15:0] o;
        logic [39:0] m;
        o = (cb && rs < 3'h5) ? OFF[rs] : 16'h0000;
        m = {fl[5:3], err, cb, typ, clip_add(ay, o), clip_add(ax, o)};
        if (typ == accel_framer_pkg::MSG_STAT)
            m = {m[39:32], fl[3], fl[4], fl[2:1], cb, fl[0], err, 1'b1, 8'h00, tp};
        return {m, 8'(~(m[39:32] + m[31:24] + m[23:16] + m[15:8] + m[7:0]))};
    endfunction
    task automatic compare(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] cmd, input logic good, input logic cmp);
        int b0;
        b0 = busy;
        if (cmp) begin
            expq.push_back(msg());
            @(posedge clk);
            ay <= ~ay;
            ax <= ~ax;
            tp <= ~tp;
        end
        host.xfer({cmd, 32'h0, good ? ~cmd : cmd}, cmp);
        compare("settle", (good && cb != cmd[6]) ? SETTLE : 0, busy - b0);
        err = !good;
        if (good) cb = cmd[6];
        if (good && cmd[3:0] inside {4'h1, 4'h2}) typ = cmd[2:0];
        compare("state", {typ, cb, err, 2'b00}, {mtype, cb_en, c_err, oe, settling});
    endtask
    task automatic step(input logic [7:0] cmd, input logic good);
        @(posedge clk);
        ay <= 16'($signed(14'($urandom)));
        ax <= 16'($signed(14'($urandom)));
        tp <= 16'($urandom);
        rs <= 3'($urandom_range(0, 7));
        fl <= 6'($urandom);
        send(cmd, good, 1'b0);
        send(cmd, 1'b1, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge done) begin
        if (expq.size() == 0) begin
            failures++;
            $display("Error response expected none seen %h", rx);
        end else
            compare("response", expq.pop_front(), rx);
    end
    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        void'($urandom(32'hECCE4008));
        typ = accel_framer_pkg::MSG_TYPE_RST;
        cb = 1'b0;
        err = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        send(8'h00, 1'b1, 1'b1);
        $display("Test reset done");
        foreach (CMDS[i]) begin
            step(CMDS[i], GOOD[i]);
            $display("Test %0d done", i);
        end
        report_and_stop();
    end
    initial begin
        #2000000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
